// [core/bbsm_map.svh]
// Constants for the block size mode selector.
`ifndef BBSM_MAP_SVH
`define BBSM_MAP_SVH
`define BBSM_LEN_STD 12'h03E8
`define BBSM_LEN_SEQ_SHORT 12'h01FF
`define BBSM_LEN_SEQ_LONG 12'h07FF
`define BBSM_LEN_W 12
`define BBSM_BOOT_WAIT 2'h3
`define BBSM_SHOW_NS 1000000
`define BBSM_CLK_NS 8
`endif

// [core/bbsm_pkg.sv]
// Types for the block size mode selector.
package bbsm_pkg;
  typedef enum logic {
    BBSM_MODE_STD,
    BBSM_MODE_SEQ
  } bbsm_mode_t;
  typedef enum logic [1:0] {
    BBSM_KEY_IDLE,
    BBSM_KEY_ARMED
  } bbsm_key_t;
endpackage

// [core/bbsm_block_count.sv]
// Counts whole blocks from received bits for a given block length.
`timescale 1ns/100ps
`include "bbsm_map.svh"
module bbsm_block_count #(
  parameter int CNT_W = 32
) (
  input wire logic clk_i, // Clock.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic clear_i, // Restart the count.
  input wire logic bit_i, // One received bit this cycle.
  input wire logic [`BBSM_LEN_W-1:0] len_i, // Active block length.
  output logic [CNT_W-1:0] blocks_o // Whole blocks received.
);
  logic [`BBSM_LEN_W-1:0] bits_q;
  logic [CNT_W-1:0] blocks_q;

  // Position of the next bit within the current block.
  function automatic logic [`BBSM_LEN_W-1:0] bit_step(input logic [`BBSM_LEN_W-1:0] pos);
    return pos + `BBSM_LEN_W'(1);
  endfunction

  // A block is counted each time the bit count reaches the block length.
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      bits_q <= '0;
      blocks_q <= '0;
    end else if (bit_i) begin
      if (bit_step(bits_q) >= len_i) begin
        bits_q <= '0;
        blocks_q <= blocks_q + CNT_W'(1);
      end else begin
        bits_q <= bit_step(bits_q);
      end
    end
  end

  assign blocks_o = blocks_q;
endmodule // bbsm_block_count

// [core/bbsm_top.sv]
// Block size mode selector for a bit error rate test set.
`timescale 1ns/100ps
`include "bbsm_map.svh"
module bbsm_top #(
  parameter int CNT_W = 32,
  parameter int SHOW_CYCLES = `BBSM_SHOW_NS / `BBSM_CLK_NS
) (
  input wire logic clk_i, // Clock, 125 MHz.
  input wire logic reset_i, // Synchronous power-up reset, active high.
  input wire logic power_up_mode_jumper_i, // High when the jumper is fitted.
  input wire logic limits_key_i, // Sequence-limits key pressed, level.
  input wire logic pattern_key_i, // Pattern key pressed, level.
  input wire logic long_seq_i, // High when sending the 2047-bit sequence.
  input wire logic bit_valid_i, // One received bit this cycle.
  input wire logic count_clear_i, // Restart block counting.
  output logic seq_mode_o, // High in sequence-length mode.
  output logic [`BBSM_LEN_W-1:0] block_len_o, // Active block length in bits.
  output logic mode_banner_o, // High while the mode indication shows.
  output logic menu_ready_o, // High once the top-level menu may show.
  output logic [CNT_W-1:0] blocks_o // Received block count.
);
  // ===========================================
  // Input synchronisers
  // ===========================================
  // Pins from outside the clock domain pass two flip-flops before any logic reads them.
  logic [1:0] jmp_s_q, lim_s_q, pat_s_q, long_s_q;
  logic lim_d_q, pat_d_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      jmp_s_q <= '0;
      lim_s_q <= '0;
      pat_s_q <= '0;
      long_s_q <= '0;
    end else begin
      jmp_s_q <= {jmp_s_q[0], power_up_mode_jumper_i};
      lim_s_q <= {lim_s_q[0], limits_key_i};
      pat_s_q <= {pat_s_q[0], pattern_key_i};
      long_s_q <= {long_s_q[0], long_seq_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lim_d_q <= 1'b0;
      pat_d_q <= 1'b0;
    end else begin
      lim_d_q <= lim_s_q[1];
      pat_d_q <= pat_s_q[1];
    end
  end

  // A press is the first cycle in which a synchronised key reads high.
  logic lim_press, pat_press;
  assign lim_press = lim_s_q[1] && !lim_d_q;
  assign pat_press = pat_s_q[1] && !pat_d_q;

  // ===========================================
  // Power-up strap capture
  // ===========================================
  // The strap is taken once, after the synchroniser has filled.
  logic [1:0] boot_q;
  logic booted;
  assign booted = (boot_q == `BBSM_BOOT_WAIT);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      boot_q <= '0;
    end else if (!booted) begin
      boot_q <= boot_q + 2'h1;
    end
  end

  // ===========================================
  // Key sequence and mode
  // ===========================================
  bbsm_pkg::bbsm_key_t key_q;
  bbsm_pkg::bbsm_mode_t mode_q;
  logic toggle;

  // True when a mode counts in blocks as long as the test sequence.
  function automatic logic mode_is_seq(input bbsm_pkg::bbsm_mode_t mode);
    return mode == bbsm_pkg::BBSM_MODE_SEQ;
  endfunction

  // A limits press arms the sequence; the next pattern press completes it.
  assign toggle = booted && (key_q == bbsm_pkg::BBSM_KEY_ARMED) && pat_press;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      key_q <= bbsm_pkg::BBSM_KEY_IDLE;
    end else begin
      case (key_q)
        bbsm_pkg::BBSM_KEY_IDLE: begin
          if (lim_press) begin
            key_q <= bbsm_pkg::BBSM_KEY_ARMED;
          end
        end
        bbsm_pkg::BBSM_KEY_ARMED: begin
          // Any pattern press ends the sequence; a fresh limits press rearms.
          if (pat_press) begin
            key_q <= bbsm_pkg::BBSM_KEY_IDLE;
          end
        end
        default: key_q <= bbsm_pkg::BBSM_KEY_IDLE;
      endcase
    end
  end

  logic strap_taken_q;
  logic strap_now;
  logic seq_mode_q;

  // The strap is looked at once, so a later jumper change cannot move the mode.
  assign strap_now = booted && !strap_taken_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_q <= bbsm_pkg::BBSM_MODE_STD;
      seq_mode_q <= 1'h0;
      strap_taken_q <= 1'h0;
    end else if (strap_now) begin
      strap_taken_q <= 1'h1;
      if (jmp_s_q[1]) begin
        mode_q <= bbsm_pkg::BBSM_MODE_STD;
        seq_mode_q <= 1'h0;
      end else begin
        mode_q <= bbsm_pkg::BBSM_MODE_SEQ;
        seq_mode_q <= 1'h1;
      end
    end else if (toggle && strap_taken_q) begin
      if (mode_is_seq(mode_q)) begin
        mode_q <= bbsm_pkg::BBSM_MODE_STD;
        seq_mode_q <= 1'h0;
      end else begin
        mode_q <= bbsm_pkg::BBSM_MODE_SEQ;
        seq_mode_q <= 1'h1;
      end
    end
  end

  // ===========================================
  // Block length
  // ===========================================
  // The length follows the mode one cycle later, and the sequence as it changes.
  logic [`BBSM_LEN_W-1:0] len_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      len_q <= `BBSM_LEN_STD;
    end else if (!mode_is_seq(mode_q)) begin
      len_q <= `BBSM_LEN_STD;
    end else begin
      len_q <= long_s_q[1] ? `BBSM_LEN_SEQ_LONG : `BBSM_LEN_SEQ_SHORT;
    end
  end

  // ===========================================
  // Power-up indication
  // ===========================================
  logic [31:0] show_q;
  logic banner_q, menu_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      show_q <= '0;
      banner_q <= 1'b0;
      menu_q <= 1'b0;
    end else if (strap_now) begin
      if (!jmp_s_q[1]) begin
        banner_q <= 1'b1;
        show_q <= 32'(SHOW_CYCLES);
      end else begin
        menu_q <= 1'b1;
      end
    end else if (banner_q) begin
      if (show_q <= 32'h0000_0001) begin
        banner_q <= 1'b0;
        menu_q <= 1'b1;
      end
      show_q <= show_q - 32'h0000_0001;
    end
  end

  // ===========================================
  // Block counting and outputs
  // ===========================================
  logic [CNT_W-1:0] blocks;
  logic [CNT_W-1:0] blocks_q;

  bbsm_block_count #(
    .CNT_W(CNT_W)
  ) u_count (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(count_clear_i),
    .bit_i(bit_valid_i),
    .len_i(len_q),
    .blocks_o(blocks)
  );

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      blocks_q <= '0;
    end else begin
      blocks_q <= blocks;
    end
  end

  // ===========================================
  // Outputs
  // ===========================================
  // Every output is a register, so nothing combinational reaches the pins.
  assign seq_mode_o = seq_mode_q;
  assign block_len_o = len_q;
  assign mode_banner_o = banner_q;
  assign menu_ready_o = menu_q;
  assign blocks_o = blocks_q;
endmodule // bbsm_top

// [dv/bbsm_props.sv]
// Port assertions for the block size mode selector.
`timescale 1ns/100ps
`include "bbsm_map.svh"
module bbsm_props #(
  parameter int CNT_W = 32,
  parameter int SHOW_CYCLES = 10
) (
  input wire logic clk_i, // Clock.
  input wire logic reset_i, // Reset.
  input wire logic pattern_key_i, // Pattern key.
  input wire logic long_seq_i, // Long sequence sent.
  input wire logic bit_valid_i, // Received bit.
  input wire logic seq_mode_o, // Sequence-length mode.
  input wire logic [`BBSM_LEN_W-1:0] block_len_o, // Block length.
  input wire logic mode_banner_o, // Mode indication.
  input wire logic menu_ready_o, // Menu may show.
  input wire logic [CNT_W-1:0] blocks_o // Block count.
);
  localparam int SHOW_M1 = SHOW_CYCLES - 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_len_std: assert property (!seq_mode_o |=> block_len_o == 12'h03E8)
    else $error("block length is not 1000 in standard mode");
  a_len_short: assert property ((seq_mode_o && !long_seq_i) [*5]
    |-> block_len_o == 12'h01FF)
    else $error("block length is not 511");
  a_len_long: assert property ((seq_mode_o && long_seq_i) [*5] |-> block_len_o == 12'h07FF)
    else $error("block length is not 2047");
  a_mode_by_keys: assert property ($changed(seq_mode_o) && menu_ready_o
    |-> $past(pattern_key_i, 3))
    else $error("mode changed without a pattern press");
  a_banner_time: assert property ($rose(mode_banner_o) |-> seq_mode_o
    ##SHOW_M1 mode_banner_o ##1 !mode_banner_o && menu_ready_o)
    else $error("indication length or menu hand-off wrong");
  a_banner_before: assert property (mode_banner_o |-> seq_mode_o && !menu_ready_o)
    else $error("indication shown outside its window");
  a_menu_holds: assert property (menu_ready_o |=> menu_ready_o)
    else $error("menu ready dropped");
  a_block_step: assert property (blocks_o != $past(blocks_o) |-> blocks_o == '0
    || blocks_o == $past(blocks_o) + 1'h1 && $past(bit_valid_i, 2))
    else $error("block count moved wrongly");
endmodule // bbsm_props
bind bbsm_top bbsm_props #(.CNT_W(CNT_W), .SHOW_CYCLES(SHOW_CYCLES)) u_props (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .pattern_key_i(pattern_key_i),
  .long_seq_i(long_seq_i),
  .bit_valid_i(bit_valid_i),
  .seq_mode_o(seq_mode_o),
  .block_len_o(block_len_o),
  .mode_banner_o(mode_banner_o),
  .menu_ready_o(menu_ready_o),
  .blocks_o(blocks_o)
);

// [dv/bbsm_panel.sv]
// Front-panel keys and power-up jumper model.
`timescale 1ns/100ps
module bbsm_panel (
  input wire logic clk_i, // Clock.
  output logic limits_o, // Limits key, high when pressed.
  output logic pattern_o, // Pattern key, high when pressed.
  output logic jumper_o // High when the jumper is fitted.
);
  initial begin
    limits_o = 1'h0;
    pattern_o = 1'h0;
    jumper_o = 1'h1;
  end
  // Presses limits (if asked) then pattern, each held ten cycles.
  task press(input logic lim);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      #1;
      if (k == 0) begin
        limits_o = lim;
      end else begin
        pattern_o = 1'h1;
      end
      repeat (10) @(posedge clk_i);
      #1;
      limits_o = 1'h0;
      pattern_o = 1'h0;
    end
  endtask
endmodule // bbsm_panel

// [dv/tb.sv]
// Self-checking bench for the block size mode selector.
`timescale 1ns/100ps
`include "bbsm_map.svh"
module tb;
  localparam int SHOW = 10;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic long_seq_i = 1'h0;
  logic bit_valid_i = 1'h0;
  logic count_clear_i = 1'h0;
  logic power_up_mode_jumper_i, limits_key_i, pattern_key_i;
  logic seq_mode_o, mode_banner_o, menu_ready_o;
  logic [`BBSM_LEN_W-1:0] block_len_o;
  logic [31:0] blocks_o;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int m_mode, m_len, m_bits;
  bbsm_top #(
    .SHOW_CYCLES(SHOW)
  ) dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .power_up_mode_jumper_i(power_up_mode_jumper_i),
    .limits_key_i(limits_key_i),
    .pattern_key_i(pattern_key_i),
    .long_seq_i(long_seq_i),
    .bit_valid_i(bit_valid_i),
    .count_clear_i(count_clear_i),
    .seq_mode_o(seq_mode_o),
    .block_len_o(block_len_o),
    .mode_banner_o(mode_banner_o),
    .menu_ready_o(menu_ready_o),
    .blocks_o(blocks_o)
  );
  bbsm_panel u_panel (.clk_i(clk_i), .limits_o(limits_key_i), .pattern_o(pattern_key_i),
    .jumper_o(power_up_mode_jumper_i));
  initial forever #4 clk_i = ~clk_i;
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    void'($urandom(49773));
    tick(6);
    reset_i = 1'h0;
    tick(8);
    chk("seq_mode", 0, seq_mode_o);
    chk("block_len", 1000, block_len_o);
    chk("menu", 1, menu_ready_o);
    $display("test strap fitted done");
    m_mode = 0;
    for (int t = 0; t < 6; t++) begin
      u_panel.press(t != 2);
      if (t != 2) m_mode = 1 - m_mode;
      // One sequence-length test always runs the long sequence.
      long_seq_i = (t == 3) ? 1'h1 : 1'($urandom_range(1, 0));
      tick(8);
      m_len = m_mode ? (long_seq_i ? 2047 : 511) : 1000;
      chk("seq_mode", m_mode, seq_mode_o);
      chk("block_len", m_len, block_len_o);
      count_clear_i = 1'h1;
      tick(1);
      count_clear_i = 1'h0;
      m_bits = $urandom_range(2 * m_len + 40, m_len - 1);
      bit_valid_i = 1'h1;
      tick(m_bits);
      bit_valid_i = 1'h0;
      tick(3);
      chk("blocks", m_bits / m_len, blocks_o);
      $display("test keys %0d done", t);
    end
    u_panel.jumper_o = 1'h0;
    reset_i = 1'h1;
    tick(6);
    reset_i = 1'h0;
    m_bits = 0;
    for (int k = 0; k < 40; k++) begin
      tick(1);
      m_bits += mode_banner_o;
    end
    chk("banner_cycles", SHOW, m_bits);
    chk("menu", 1, menu_ready_o);
    chk("seq_mode", 1, seq_mode_o);
    chk("block_len", long_seq_i ? 2047 : 511, block_len_o);
    $display("test strap removed done");
    test_done();
  end
endmodule // tb
